// File: pkg/dst_params.svh
// Purpose: offsets, field positions, masks and reset values of the
//          dual 8-bit split timer register map.
// Assumes: register index times four is the Avalon byte address.
// Notes:   indices keep the printed offsets; data sits in lane 0.
`ifndef DST_PARAMS_SVH
`define DST_PARAMS_SVH

// register indices (byte address = 4 * index)
`define DST_IDX_TIMER_CONTROL 6'h00
`define DST_IDX_CHANNEL_ENABLE 6'h01
`define DST_IDX_OUTPUT_VALUE 6'h02
`define DST_IDX_SPLIT_SELECT 6'h03
`define DST_IDX_COMMAND_CLEAR 6'h04
`define DST_IDX_COMMAND_SET 6'h05
`define DST_IDX_INT_ENABLE 6'h0A
`define DST_IDX_INT_FLAGS 6'h0B
`define DST_IDX_DEBUG_CONTROL 6'h0E
`define DST_IDX_LOW_COUNTER 6'h20
`define DST_IDX_HIGH_COUNTER 6'h21
`define DST_IDX_LOW_PERIOD 6'h26
`define DST_IDX_HIGH_PERIOD 6'h27
`define DST_IDX_COMPARE_BASE 6'h28
`define DST_IDX_COMPARE_LAST 6'h2D

// field positions
`define DST_BIT_ENABLE 0
`define DST_BIT_PRESCALE_LSB 1
`define DST_BIT_SPLIT 0
`define DST_BIT_RUN_HALTED 0
`define DST_BIT_CMD_LSB 2
`define DST_BIT_LOWER_UNF 0
`define DST_BIT_UPPER_UNF 1
`define DST_BIT_LOW_MATCH0 4
`define DST_HIGH_CHAN_LSB 4

// writable-bit masks
`define DST_CHAN_MASK 8'h77
`define DST_INT_MASK 8'h73
`define DST_ESTAT_MASK 8'h03

// reset values
`define DST_RESET_BYTE 8'h00
`define DST_RESET_PERIOD 8'h00
`define DST_RESET_COMPARE 8'h00

`endif

// File: pkg/dst_pkg.sv
// Purpose: types shared by the dual 8-bit split timer.
// Assumes: constants live in dst_params.svh.
// Notes:   the whole timer state is one packed struct.
package dst_pkg;

  // command field codes, in field order
  typedef enum logic [1:0] {
    CMD_NONE, CMD_UPDATE, CMD_RESTART, CMD_HARD_RESET
  } dst_cmd_t;

  // bus slave phase
  typedef enum logic {BUS_IDLE, BUS_ACK} dst_bus_state_t;

  // one Avalon request as seen by the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] index;
    logic [7:0] wdata;
    logic lane0;
  } dst_avs_req_t;

  // complete register and timer state
  typedef struct packed {
    dst_bus_state_t bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [2:0] prescale_select;
    logic enable;
    logic [7:0] channel_enable;
    logic [7:0] output_value_control;
    logic split_mode_select;
    logic [7:0] e_status;
    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_flags;
    logic run_while_halted;
    logic [9:0] prescale_count;
    logic [7:0] low_counter;
    logic [7:0] high_counter;
    logic [7:0] low_period;
    logic [7:0] high_period;
    logic [2:0][7:0] low_compare;
    logic [2:0][7:0] high_compare;
    logic [5:0] waveform;
    logic [5:0] override;
    logic [7:0] irq;
  } dst_state_t;

endpackage : dst_pkg

// File: design/dst_timer.sv
// Purpose: dual 8-bit down-counting split timer with Avalon-MM slave.
// Assumes: one 10 MHz clock; pins and debug halt synchronous to it.
// Notes:   waveform bits [2:0] low channels, [5:3] high channels.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "dst_params.svh"

module dst_timer (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Avalon-MM slave, byte address
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // processor halted in break debug
  input wire logic i_debug_halt,
  // waveform pins and port override
  output logic [5:0] o_waveform_pin,
  output logic [5:0] o_waveform_override,
  // gated interrupt requests, flag layout
  output logic [7:0] o_irq_request
);

  dst_pkg::dst_state_t s; // registered state
  dst_pkg::dst_state_t next_s; // next state
  dst_pkg::dst_avs_req_t req; // packed bus request
  logic wr_now; // write takes effect this edge
  logic running; // timer advances this cycle
  logic tick; // prescaled count enable
  logic [9:0] pmask; // prescaler mask

  // divide mask for each prescale code
  function automatic logic [9:0] prescale_mask(input logic [2:0] sel);
    case (sel)
      3'h0: prescale_mask = 10'h000;
      3'h1: prescale_mask = 10'h001;
      3'h2: prescale_mask = 10'h003;
      3'h3: prescale_mask = 10'h007;
      3'h4: prescale_mask = 10'h00F;
      3'h5: prescale_mask = 10'h03F;
      3'h6: prescale_mask = 10'h0FF;
      default: prescale_mask = 10'h3FF;
    endcase
  endfunction : prescale_mask

  // register read mux; split layout only visible in split mode
  function automatic logic [7:0] reg_read(
    input dst_pkg::dst_state_t st,
    input logic [5:0] idx
  );
    logic split_only;
    split_only = (idx >= `DST_IDX_INT_ENABLE) &&
                 (idx != `DST_IDX_DEBUG_CONTROL);
    reg_read = 8'h00;
    if (!split_only || st.split_mode_select) begin
      case (idx)
        `DST_IDX_TIMER_CONTROL:
          reg_read = {4'h0, st.prescale_select, st.enable};
        `DST_IDX_CHANNEL_ENABLE: reg_read = st.channel_enable;
        `DST_IDX_OUTPUT_VALUE: reg_read = st.output_value_control;
        `DST_IDX_SPLIT_SELECT: reg_read = {7'h00, st.split_mode_select};
        // both views show one status; command bits stay zero
        `DST_IDX_COMMAND_CLEAR,
        `DST_IDX_COMMAND_SET: reg_read = st.e_status;
        `DST_IDX_INT_ENABLE: reg_read = st.interrupt_enable;
        `DST_IDX_INT_FLAGS: reg_read = st.interrupt_flags;
        `DST_IDX_DEBUG_CONTROL: reg_read = {7'h00, st.run_while_halted};
        `DST_IDX_LOW_COUNTER: reg_read = st.low_counter;
        `DST_IDX_HIGH_COUNTER: reg_read = st.high_counter;
        `DST_IDX_LOW_PERIOD: reg_read = st.low_period;
        `DST_IDX_HIGH_PERIOD: reg_read = st.high_period;
        default: begin
          // compare block: even index low, odd index high
          if (idx >= `DST_IDX_COMPARE_BASE &&
              idx <= `DST_IDX_COMPARE_LAST) begin
            if (idx[0])
              reg_read = st.high_compare[2'((idx - 6'h28) >> 1)];
            else
              reg_read = st.low_compare[2'((idx - 6'h28) >> 1)];
          end
        end
      endcase
    end
  endfunction : reg_read

  // pack the Avalon request, word index from byte address
  assign req.read = i_avs_read;
  assign req.write = i_avs_write;
  assign req.index = i_avs_address[7:2];
  assign req.wdata = i_avs_writedata[7:0];
  assign req.lane0 = i_avs_byteenable[0];

  // outputs straight from state flops
  assign o_avs_readdata = s.rdata;
  assign o_avs_waitrequest = s.waitreq;
  assign o_waveform_pin = s.waveform;
  assign o_waveform_override = s.override;
  assign o_irq_request = s.irq;

  // write lands on the edge where waitrequest is seen low
  assign wr_now = (s.bus == dst_pkg::BUS_ACK) && req.write && req.lane0;
  // runs only enabled, split, and not frozen by debug halt
  assign running = s.enable && s.split_mode_select &&
                   (!i_debug_halt || s.run_while_halted);
  assign pmask = prescale_mask(s.prescale_select);
  assign tick = running &&
                ((s.prescale_count & pmask) == pmask);

  // next-state logic: bus, counting, compares, writes, commands
  always_comb begin
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic [1:0] cmd;
    logic [2:0] cidx;
    set_f = 8'h00;
    clr_f = 8'h00;
    cmd = 2'h0;
    cidx = 3'h0;
    next_s = s;

    // bus handshake: one wait cycle, then one ready cycle
    case (s.bus)
      dst_pkg::BUS_IDLE: begin
        if (req.read || req.write) begin
          next_s.bus = dst_pkg::BUS_ACK;
          next_s.waitreq = 1'b0;
          next_s.rdata = {24'h000000, reg_read(s, req.index)};
        end
      end
      dst_pkg::BUS_ACK: begin
        next_s.bus = dst_pkg::BUS_IDLE;
        next_s.waitreq = 1'b1;
        next_s.rdata = 32'h00000000;
      end
      default: begin
        next_s.bus = dst_pkg::BUS_IDLE;
        next_s.waitreq = 1'b1;
      end
    endcase

    // prescaler: cleared while disabled, held while halted
    if (!s.enable)
      next_s.prescale_count = 10'h000;
    else if (running)
      next_s.prescale_count = s.prescale_count + 10'h001;

    // down count, reload from period at zero
    if (tick) begin
      if (s.low_counter == 8'h00) begin
        next_s.low_counter = s.low_period;
        set_f[`DST_BIT_LOWER_UNF] = 1'b1;
      end else begin
        next_s.low_counter = s.low_counter - 8'h01;
      end
      if (s.high_counter == 8'h00) begin
        next_s.high_counter = s.high_period;
        set_f[`DST_BIT_UPPER_UNF] = 1'b1;
      end else begin
        next_s.high_counter = s.high_counter - 8'h01;
      end
    end

    // continuous compare; low matches raise flags
    for (int n = 0; n < 3; n++) begin
      if (s.split_mode_select &&
          s.low_counter == s.low_compare[n])
        set_f[`DST_BIT_LOW_MATCH0 + n] = 1'b1;
    end

    // register writes; counter writes override counting
    if (wr_now) begin
      case (req.index)
        `DST_IDX_TIMER_CONTROL: begin
          next_s.enable = req.wdata[`DST_BIT_ENABLE];
          next_s.prescale_select = req.wdata[3:1];
        end
        `DST_IDX_CHANNEL_ENABLE:
          next_s.channel_enable = req.wdata & `DST_CHAN_MASK;
        `DST_IDX_OUTPUT_VALUE:
          next_s.output_value_control = req.wdata & `DST_CHAN_MASK;
        `DST_IDX_SPLIT_SELECT:
          next_s.split_mode_select = req.wdata[`DST_BIT_SPLIT];
        `DST_IDX_COMMAND_CLEAR: begin
          next_s.e_status = s.e_status &
                            ~(req.wdata & `DST_ESTAT_MASK);
          cmd = req.wdata[3:2];
        end
        `DST_IDX_COMMAND_SET: begin
          next_s.e_status = s.e_status |
                            (req.wdata & `DST_ESTAT_MASK);
          cmd = req.wdata[3:2];
        end
        `DST_IDX_DEBUG_CONTROL:
          next_s.run_while_halted = req.wdata[`DST_BIT_RUN_HALTED];
        default: begin
          // split-layout registers only exist in split mode
          if (s.split_mode_select) begin
            if (req.index == `DST_IDX_INT_ENABLE)
              next_s.interrupt_enable = req.wdata & `DST_INT_MASK;
            else if (req.index == `DST_IDX_INT_FLAGS)
              clr_f = req.wdata & `DST_INT_MASK;
            else if (req.index == `DST_IDX_LOW_COUNTER)
              next_s.low_counter = req.wdata;
            else if (req.index == `DST_IDX_HIGH_COUNTER)
              next_s.high_counter = req.wdata;
            else if (req.index == `DST_IDX_LOW_PERIOD)
              next_s.low_period = req.wdata;
            else if (req.index == `DST_IDX_HIGH_PERIOD)
              next_s.high_period = req.wdata;
            else if (req.index >= `DST_IDX_COMPARE_BASE &&
                     req.index <= `DST_IDX_COMPARE_LAST) begin
              cidx = 3'((req.index - 6'h28) >> 1);
              if (req.index[0])
                next_s.high_compare[cidx[1:0]] = req.wdata;
              else
                next_s.low_compare[cidx[1:0]] = req.wdata;
            end
          end
        end
      endcase
    end

    // command decode; the field itself is never stored
    case (cmd)
      2'h0: ; // no command
      2'h1: ; // update: split layout has no buffered values
      2'h2: begin
        // restart: prescaler and both counters from top
        next_s.prescale_count = 10'h000;
        next_s.low_counter = s.low_period;
        next_s.high_counter = s.high_period;
      end
      2'h3: begin
        if (!s.enable) begin
          // hard reset of timer contents
          next_s.prescale_count = 10'h000;
          next_s.low_counter = `DST_RESET_BYTE;
          next_s.high_counter = `DST_RESET_BYTE;
          next_s.low_period = `DST_RESET_PERIOD;
          next_s.high_period = `DST_RESET_PERIOD;
          next_s.low_compare = {3{`DST_RESET_COMPARE}};
          next_s.high_compare = {3{`DST_RESET_COMPARE}};
          next_s.e_status = `DST_RESET_BYTE;
          clr_f = 8'hFF;
        end
      end
      default: ;
    endcase

    // set beats clear when both land together
    next_s.interrupt_flags = ((s.interrupt_flags & ~clr_f) | set_f) &
                             `DST_INT_MASK;

    // enables gate flags onto requests
    next_s.irq = next_s.interrupt_flags &
                 next_s.interrupt_enable;

    // waveform: single-slope compare while enabled
    for (int n = 0; n < 3; n++) begin
      if (!s.enable) begin
        next_s.waveform[n] = s.output_value_control[n];
        next_s.waveform[n + 3] =
          s.output_value_control[`DST_HIGH_CHAN_LSB + n];
      end else begin
        next_s.waveform[n] = s.low_counter < s.low_compare[n];
        next_s.waveform[n + 3] = s.high_counter < s.high_compare[n];
      end
      // split layout is always a pwm mode, so enable takes the pin
      next_s.override[n] = s.split_mode_select &&
                           s.channel_enable[n];
      next_s.override[n + 3] = s.split_mode_select &&
        s.channel_enable[`DST_HIGH_CHAN_LSB + n];
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
      s.bus <= dst_pkg::BUS_IDLE;
      s.waitreq <= 1'b1;
      s.low_period <= `DST_RESET_PERIOD;
      s.high_period <= `DST_RESET_PERIOD;
    end else begin
      s <= next_s;
    end
  end

  // checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  // helper: no command is being written this cycle
  function automatic logic cmd_idle();
    cmd_idle = !(wr_now && (req.index == `DST_IDX_COMMAND_SET ||
                            req.index == `DST_IDX_COMMAND_CLEAR));
  endfunction : cmd_idle

  chk_bus_handshake: assert property (
    (s.bus == dst_pkg::BUS_IDLE && (req.read || req.write))
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one ready cycle");

  chk_cmd_reads_zero: assert property (
    (s.bus == dst_pkg::BUS_IDLE && req.read &&
     (req.index == `DST_IDX_COMMAND_SET ||
      req.index == `DST_IDX_COMMAND_CLEAR))
      |=> o_avs_readdata[3:2] == 2'b00)
    else $error("command field read back nonzero");

  chk_hard_reset_gate: assert property (
    (wr_now && req.index == `DST_IDX_COMMAND_SET &&
     req.wdata[3:2] == 2'h3 && s.enable)
      |=> s.low_period == $past(s.low_period) &&
          s.high_compare == $past(s.high_compare))
    else $error("hard reset acted while enabled");

  chk_flag_sticky: assert property (
    (s.interrupt_flags[`DST_BIT_LOW_MATCH0] &&
     !(wr_now && req.index == `DST_IDX_INT_FLAGS))
      |=> s.interrupt_flags[`DST_BIT_LOW_MATCH0])
    else $error("compare flag cleared without write");

  chk_low_match: assert property (
    (s.split_mode_select && s.low_counter == s.low_compare[1])
      |=> s.interrupt_flags[`DST_BIT_LOW_MATCH0 + 1])
    else $error("low compare match lost");

  chk_low_reload: assert property (
    (tick && s.low_counter == 8'h00 && !wr_now && cmd_idle())
      |=> s.low_counter == $past(s.low_period) &&
          s.interrupt_flags[`DST_BIT_LOWER_UNF])
    else $error("low timer reload or flag wrong");

  chk_high_reload: assert property (
    (tick && s.high_counter == 8'h00 && !wr_now)
      |=> s.interrupt_flags[`DST_BIT_UPPER_UNF])
    else $error("high underflow flag missing");

  chk_halt_freeze: assert property (
    (i_debug_halt && !s.run_while_halted && !wr_now)
      |=> $stable(s.low_counter) && $stable(s.high_counter))
    else $error("timer moved during debug halt");

  chk_count_write: assert property (
    (wr_now && s.split_mode_select &&
     req.index == `DST_IDX_LOW_COUNTER)
      |=> s.low_counter == $past(req.wdata))
    else $error("counter write lost to counting");

  chk_idle_value: assert property (
    !s.enable |=> o_waveform_pin[0] == $past(s.output_value_control[0]))
    else $error("idle pin not from value bit");

  chk_irq_gate: assert property (
    !s.interrupt_enable[`DST_BIT_LOWER_UNF] ##1
    !s.interrupt_enable[`DST_BIT_LOWER_UNF]
      |-> !o_irq_request[`DST_BIT_LOWER_UNF])
    else $error("masked underflow reached request");

  cov_low_underflow: cover property (
    tick && s.low_counter == 8'h00);
  cov_high_match: cover property (
    s.enable && s.high_counter == s.high_compare[0]);
  cov_halt_hold: cover property (
    s.enable && i_debug_halt && !s.run_while_halted);
  cov_hard_reset: cover property (
    wr_now && req.index == `DST_IDX_COMMAND_SET &&
    req.wdata[3:2] == 2'h3 && !s.enable);

endmodule : dst_timer

// File: verif/dst_timer_tb.sv
// Purpose: self-checking bench for the dual 8-bit split timer.
// Assumes: 100 ns clock; bus answer taken at the rising edge.
// Notes: pins sampled on the falling edge, inputs change on rise.
`timescale 1ns/100ps

module dst_timer_tb;
  // bus and debug stimulus
  logic i_clock;
  logic i_reset_n;
  logic [7:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  logic i_debug_halt;
  // observed outputs
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [5:0] o_waveform_pin;
  logic [5:0] o_waveform_override;
  logic [7:0] o_irq_request;
  // scoreboard and last read value
  int error_cnt;
  int checks;
  logic [31:0] rv;

  dst_timer i_dst_timer (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_debug_halt(i_debug_halt),
    .o_waveform_pin(o_waveform_pin),
    .o_waveform_override(o_waveform_override),
    .o_irq_request(o_irq_request)
  );

  // free running clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // compare seen against expected, count both outcomes
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one access, held until waitrequest low is seen at a rising edge
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd, input logic [3:0] be);
    @(posedge i_clock);
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h000000, wd};
    i_avs_byteenable <= be;
    i_avs_read <= ~wr;
    i_avs_write <= wr;
    // outputs move only in the update phase, so this is the value
    // the slave showed at the edge itself
    do begin
      @(posedge i_clock);
    end while (o_avs_waitrequest !== 1'b0);
    rv = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus

  // byte write in lane 0
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, 4'h1);
  endtask : wr

  // read and compare whole word
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    check(rv, exp);
  endtask : rd_chk

  // let settled outputs be seen
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask : idle

  // reset values, layout switch, unmapped place, lane gating
  task automatic t_reset_map;
    logic [5:0] tbl [7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
                            6'h0E};
    foreach (tbl[i]) rd_chk(tbl[i], 32'h0);
    wr(6'h26, 8'h55);
    rd_chk(6'h26, 32'h0);
    wr(6'h03, 8'h01);
    rd_chk(6'h03, 32'h1);
    wr(6'h26, 8'h55);
    rd_chk(6'h26, 32'h55);
    rd_chk(6'h20, 32'h0);
    rd_chk(6'h21, 32'h0);
    rd_chk(6'h0A, 32'h0);
    // counters and compares all zero, so every low match is set
    rd_chk(6'h0B, 32'h70);
    wr(6'h07, 8'hFF);
    rd_chk(6'h07, 32'h0);
    bus(1'b1, 6'h27, 8'hAA, 4'h0);
    rd_chk(6'h27, 32'h0);
  endtask : t_reset_map

  // value bits drive pins while stopped, enables take pins over
  task automatic t_outputs;
    wr(6'h02, 8'hFF);
    rd_chk(6'h02, 32'h77);
    wr(6'h01, 8'hFF);
    rd_chk(6'h01, 32'h77);
    wr(6'h02, 8'h25);
    wr(6'h01, 8'h12);
    idle(2);
    check(32'(o_waveform_pin), 32'h15);
    check(32'(o_waveform_override), 32'h0A);
    wr(6'h01, 8'h00);
    idle(2);
    check(32'(o_waveform_override), 32'h00);
  endtask : t_outputs

  // compare match flags, sticky clearing, interrupt gating
  task automatic t_compare_flags;
    wr(6'h28, 8'h10);
    wr(6'h2A, 8'h11);
    wr(6'h2C, 8'h12);
    wr(6'h0B, 8'h70);
    rd_chk(6'h0B, 32'h0);
    wr(6'h20, 8'h10);
    rd_chk(6'h0B, 32'h10);
    wr(6'h0A, 8'h10);
    idle(2);
    check(32'(o_irq_request), 32'h10);
    wr(6'h0A, 8'h20);
    idle(2);
    check(32'(o_irq_request), 32'h00);
    wr(6'h20, 8'h20);
    wr(6'h0B, 8'h00);
    rd_chk(6'h0B, 32'h10);
    wr(6'h0B, 8'h10);
    rd_chk(6'h0B, 32'h0);
  endtask : t_compare_flags

  // both timers run at full rate and hit zero
  task automatic t_underflow;
    wr(6'h26, 8'h03);
    wr(6'h27, 8'h05);
    wr(6'h20, 8'h00);
    wr(6'h21, 8'h00);
    wr(6'h0A, 8'h03);
    wr(6'h00, 8'h01);
    idle(20);
    wr(6'h20, 8'h02);
    wr(6'h00, 8'h00);
    bus(1'b0, 6'h0B, 8'h00, 4'h1);
    check(rv & 32'h3, 32'h3);
    check(32'(o_irq_request & 8'h03), 32'h3);
    wr(6'h0B, 8'h01);
    bus(1'b0, 6'h0B, 8'h00, 4'h1);
    check(rv & 32'h3, 32'h2);
    wr(6'h0B, 8'h02);
    bus(1'b0, 6'h0B, 8'h00, 4'h1);
    check(rv & 32'h3, 32'h0);
  endtask : t_underflow

  // two and a half divider periods give exactly two ticks
  task automatic t_prescale(input logic [2:0] code, input int div);
    wr(6'h20, 8'hF0);
    wr(6'h00, {4'h0, code, 1'b1});
    idle(div * 5 / 2);
    rd_chk(6'h20, 32'hEE);
    wr(6'h00, 8'h00);
  endtask : t_prescale

  // slowest rate: reload from period, then software write wins
  task automatic t_reload;
    wr(6'h20, 8'h00);
    wr(6'h26, 8'h66);
    wr(6'h21, 8'h00);
    wr(6'h27, 8'h77);
    wr(6'h00, 8'h0F);
    idle(1536);
    rd_chk(6'h20, 32'h66);
    rd_chk(6'h21, 32'h77);
    wr(6'h20, 8'h33);
    rd_chk(6'h20, 32'h33);
    wr(6'h21, 8'h44);
    rd_chk(6'h21, 32'h44);
    wr(6'h00, 8'h00);
  endtask : t_reload

  // halted processor freezes the timer unless run bit set
  task automatic t_debug;
    @(posedge i_clock);
    i_debug_halt <= 1'b1;
    wr(6'h26, 8'hFF);
    wr(6'h20, 8'h40);
    wr(6'h00, 8'h01);
    idle(10);
    rd_chk(6'h20, 32'h40);
    wr(6'h0E, 8'h01);
    rd_chk(6'h0E, 32'h1);
    idle(10);
    bus(1'b0, 6'h20, 8'h00, 4'h1);
    check(32'(rv == 32'h40), 32'h0);
    wr(6'h00, 8'h00);
    wr(6'h0E, 8'h00);
    @(posedge i_clock);
    i_debug_halt <= 1'b0;
  endtask : t_debug

  // set/clear status, command codes, hard reset gating
  task automatic t_commands;
    wr(6'h26, 8'h40);
    wr(6'h27, 8'h50);
    wr(6'h20, 8'h05);
    wr(6'h21, 8'h06);
    wr(6'h05, 8'h08);
    rd_chk(6'h20, 32'h40);
    rd_chk(6'h21, 32'h50);
    wr(6'h05, 8'h03);
    rd_chk(6'h05, 32'h03);
    rd_chk(6'h04, 32'h03);
    wr(6'h04, 8'h01);
    rd_chk(6'h05, 32'h02);
    wr(6'h05, 8'h04);
    rd_chk(6'h05, 32'h02);
    wr(6'h05, 8'h00);
    rd_chk(6'h04, 32'h02);
    wr(6'h00, 8'h0F);
    wr(6'h05, 8'h0C);
    rd_chk(6'h26, 32'h40);
    wr(6'h00, 8'h00);
    wr(6'h04, 8'h0C);
    rd_chk(6'h26, 32'h00);
    rd_chk(6'h05, 32'h00);
  endtask : t_commands

  // print counts and verdict, end the run
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // watchdog, well beyond the expected run of about 2800 cycles
  initial begin
    #(100 * 40000);
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial begin
    i_reset_n = 1'b0;
    i_avs_address = 8'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    i_debug_halt = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    t_reset_map();
    t_outputs();
    t_compare_flags();
    t_underflow();
    // codes 1..3 divide by 2**c, codes 4..6 by 4**(c-2)
    for (int c = 1; c < 7; c++) begin
      t_prescale(3'(c), (c < 4) ? (1 << c) : (1 << (2 * c - 4)));
    end
    t_reload();
    t_debug();
    t_commands();
    wrap_up();
  end
endmodule : dst_timer_tb
